// *** design/aux_aux_fade_times_current_regs.sv ***
`timescale 1ns/1ps
module aux_aux_fade_times_current_regs
  import aux_led_pkg::*;
#(
  parameter int TICK_CYCLES = FADE_TICK_CYC
)(
  input  wire logic                           clk_sys,
  input  wire logic                           rst,
  input  wire logic [aux_led_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [aux_led_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                           reg_we,
  input  wire logic                           reg_re,
  output logic      [aux_led_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic [aux_led_pkg::SINKS-1:0]  aux_sink_enable,
  output logic      [aux_led_pkg::CODE_W-1:0] sink0_drive,
  output logic      [aux_led_pkg::CODE_W-1:0] sink1_drive,
  output logic      [aux_led_pkg::CODE_W-1:0] sink2_drive,
  output logic      [aux_led_pkg::SINKS-1:0]  sink_on
);

  import aux_led_pkg::*;

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  // ==========================================================
  // registers
  logic [TIME_W-1:0] aux_fade_out_code_r;
  logic [TIME_W-1:0] aux_fade_in_code_r;
  logic [CODE_W-1:0] sink0_current_code_r;
  logic [CODE_W-1:0] sink1_current_code_r;
  logic [CODE_W-1:0] sink2_current_code_r;
  logic [DATA_W-1:0] reg_rdata_r;
  logic [DATA_W-1:0] reg_rdata_nxt;

  // ==========================================================
  // address decode
  wire hit_fade  = reg_addr == OFS_FADE_TIMES;
  wire hit_cur0  = reg_addr == OFS_SINK0_CUR;
  wire hit_cur1  = reg_addr == OFS_SINK1_CUR;
  wire hit_cur2  = reg_addr == OFS_SINK2_CUR;
  wire wr_fade   = reg_we && hit_fade;
  wire wr_cur0   = reg_we && hit_cur0;
  wire wr_cur1   = reg_we && hit_cur1;
  wire wr_cur2   = reg_we && hit_cur2;

  wire [DATA_W-1:0] fade_word = {aux_fade_out_code_r, aux_fade_in_code_r};
  wire [DATA_W-1:0] cur0_word = {2'h0, sink0_current_code_r};
  wire [DATA_W-1:0] cur1_word = {2'h0, sink1_current_code_r};
  wire [DATA_W-1:0] cur2_word = {2'h0, sink2_current_code_r};

  wire [DATA_W-1:0] rd_mux = hit_fade ? fade_word :
                             hit_cur0 ? cur0_word :
                             hit_cur1 ? cur1_word :
                             hit_cur2 ? cur2_word : RD_UNMAPPED;

  assign reg_rdata_nxt = reg_re ? rd_mux : reg_rdata_r;

  // ==========================================================
  // register writes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aux_fade_out_code_r <= RST_FADE_TIMES[FO_MSB:FO_LSB];
      aux_fade_in_code_r  <= RST_FADE_TIMES[FI_MSB:FI_LSB];
    end else if (wr_fade) begin
      aux_fade_out_code_r <= reg_wdata[FO_MSB:FO_LSB];
      aux_fade_in_code_r  <= reg_wdata[FI_MSB:FI_LSB];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sink0_current_code_r <= RST_CUR_CODE;
    end else if (wr_cur0) begin
      sink0_current_code_r <= reg_wdata[CUR_MSB:CUR_LSB];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sink1_current_code_r <= RST_CUR_CODE;
    end else if (wr_cur1) begin
      sink1_current_code_r <= reg_wdata[CUR_MSB:CUR_LSB];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sink2_current_code_r <= RST_CUR_CODE;
    end else if (wr_cur2) begin
      sink2_current_code_r <= reg_wdata[CUR_MSB:CUR_LSB];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata_r <= RD_UNMAPPED;
    end else begin
      reg_rdata_r <= reg_rdata_nxt;
    end
  end

  assign reg_rdata = reg_rdata_r;

  // ==========================================================
  // fade tick divider
  logic [TICK_W-1:0] tick_cnt_r;
  logic [TICK_W-1:0] tick_cnt_nxt;
  logic              tick_r;

  wire tick_wrap = tick_cnt_r == TICK_W'(TICK_CYCLES - 1);

  assign tick_cnt_nxt = tick_wrap ? '0 : tick_cnt_r + TICK_W'(1);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r     <= tick_wrap;
    end
  end

  // ==========================================================
  // shared fade timing to the ramps
  fade_if fade ();

  assign fade.tick       = tick_r;
  assign fade.in_tenths  = fade_tenths(aux_fade_in_code_r);
  assign fade.out_tenths = fade_tenths(aux_fade_out_code_r);

  // ==========================================================
  // per-sink ramps
  logic [CODE_W-1:0] target [SINKS];
  logic [CODE_W-1:0] drive  [SINKS];

  assign target[0] = sink0_current_code_r;
  assign target[1] = sink1_current_code_r;
  assign target[2] = sink2_current_code_r;

  for (genvar i = 0; i < SINKS; i++) begin : g_sink
    aux_sink_ramp u_ramp (
      .clk_sys (clk_sys),
      .rst     (rst),
      .fade    (fade.ramp),
      .enable  (aux_sink_enable[i]),
      .target  (target[i]),
      .applied (drive[i])
    );
    assign sink_on[i] = drive[i] != RST_CUR_CODE;
  end

  assign sink0_drive = drive[0];
  assign sink1_drive = drive[1];
  assign sink2_drive = drive[2];

endmodule : aux_aux_fade_times_current_regs

// *** design/aux_sink_ramp.sv ***
`timescale 1ns/1ps
module aux_sink_ramp
  import aux_led_pkg::*;
(
  input  wire logic                           clk_sys,
  input  wire logic                           rst,
  fade_if.ramp                                fade,
  input  wire logic                           enable,
  input  wire logic [aux_led_pkg::CODE_W-1:0] target,
  output logic      [aux_led_pkg::CODE_W-1:0] applied
);

  import aux_led_pkg::*;

  // ==========================================================
  // direction and step pacing
  logic [CODE_W-1:0]   applied_r;
  logic [CODE_W-1:0]   applied_nxt;
  logic [TENTHS_W-1:0] div_r;
  logic [TENTHS_W-1:0] div_nxt;

  wire [CODE_W-1:0]   goal    = enable ? target : RST_CUR_CODE;
  wire                rising  = goal > applied_r;
  wire                at_goal = goal == applied_r;
  wire [TENTHS_W-1:0] dur     = rising ? fade.in_tenths : fade.out_tenths;
  wire                no_ramp = dur == '0;
  wire                step    = fade.tick && (div_r + 6'h01 >= dur);
  wire [CODE_W-1:0]   toward  = rising ? applied_r + 6'h01 : applied_r - 6'h01;

  // one code step per dur ticks, 64 ticks per tenth of a second
  assign applied_nxt = at_goal ? applied_r : (no_ramp ? goal : (step ? toward : applied_r));
  assign div_nxt     = (at_goal || no_ramp || step) ? '0 : (fade.tick ? div_r + 6'h01 : div_r);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      applied_r <= RST_CUR_CODE;
      div_r     <= '0;
    end else begin
      applied_r <= applied_nxt;
      div_r     <= div_nxt;
    end
  end

  assign applied = applied_r;

endmodule : aux_sink_ramp

// *** shared/aux_led_pkg.sv ***
package aux_led_pkg;

  // ==========================================================
  // widths
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 8;
  localparam int CODE_W   = 6;
  localparam int TIME_W   = 4;
  localparam int TENTHS_W = 6;
  localparam int SINKS    = 3;

  // ==========================================================
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_FADE_TIMES = 8'h13;
  localparam logic [ADDR_W-1:0] OFS_SINK0_CUR  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_SINK1_CUR  = 8'h15;
  localparam logic [ADDR_W-1:0] OFS_SINK2_CUR  = 8'h16;

  // ==========================================================
  // field positions
  localparam int FO_MSB  = 7;
  localparam int FO_LSB  = 4;
  localparam int FI_MSB  = 3;
  localparam int FI_LSB  = 0;
  localparam int CUR_MSB = 5;
  localparam int CUR_LSB = 0;

  // ==========================================================
  // reset values
  localparam logic [DATA_W-1:0] RST_FADE_TIMES = 8'h00;
  localparam logic [CODE_W-1:0] RST_CUR_CODE   = 6'h00;
  localparam logic [DATA_W-1:0] RD_UNMAPPED    = 8'h00;

  // ==========================================================
  // time code decode
  localparam logic [TIME_W-1:0]   CODE_FINE_MAX   = 4'hA;
  localparam logic [TENTHS_W-1:0] FINE_STEP       = 6'h03;
  localparam logic [TENTHS_W-1:0] COARSE_BASE     = 6'h23;
  localparam logic [TENTHS_W-1:0] COARSE_STEP     = 6'h05;
  localparam logic [TIME_W-1:0]   CODE_COARSE_MIN = 4'hB;

  // ==========================================================
  // timing: one fade tick is a 64th of 0.1 s
  localparam int CLK_NS         = 100;
  localparam int FADE_BASE_NS   = 1562500;
  localparam int FADE_TICK_CYC  = FADE_BASE_NS / CLK_NS;

  // fade duration in tenths of a second, zero means no ramp
  function automatic logic [TENTHS_W-1:0] fade_tenths(input logic [TIME_W-1:0] code);
    logic [TENTHS_W-1:0] c;
    c = {2'h0, code};
    if (code <= CODE_FINE_MAX) begin
      fade_tenths = TENTHS_W'(c * FINE_STEP);
    end else begin
      fade_tenths = TENTHS_W'(COARSE_BASE + COARSE_STEP * TENTHS_W'(c - {2'h0, CODE_COARSE_MIN}));
    end
  endfunction : fade_tenths

endpackage : aux_led_pkg

// *** shared/fade_if.sv ***
`timescale 1ns/1ps
interface fade_if;
  import aux_led_pkg::*;
  logic                tick;
  logic [TENTHS_W-1:0] in_tenths;
  logic [TENTHS_W-1:0] out_tenths;
  modport ctrl (output tick, output in_tenths, output out_tenths);
  modport ramp (input tick, input in_tenths, input out_tenths);
endinterface : fade_if

// *** tb/aux_aux_fade_times_current_regs_tb_top.sv ***
`timescale 1ns/1ps
module aux_aux_fade_times_current_regs_tb_top;
  import aux_led_pkg::*;
  localparam int TICKS = 4;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, v, lfsr = 8'h14;
  logic reg_we, reg_re, re_q = 1'b0;
  logic [SINKS-1:0] en = '0, on;
  logic [CODE_W-1:0] d0, d1, d2;
  logic [CODE_W-1:0] cs [3];
  logic [DATA_W-1:0] expq [$];
  int n_fail = 0, check_count = 0, n;
  always #50 clk_sys = ~clk_sys;
  aux_led_host i_aux_led_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re));
  aux_aux_fade_times_current_regs #(.TICK_CYCLES(TICKS)) i_aux_aux_fade_times_current_regs (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .aux_sink_enable(en), .sink0_drive(d0), .sink1_drive(d1), .sink2_drive(d2), .sink_on(on));
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction : rnd
  // fade duration in tenths of a second for a time code
  function automatic logic [7:0] tenths(input logic [3:0] c);
    return (c <= 4'hA) ? 8'(3 * c) : 8'(35 + 5 * (c - 11));
  endfunction : tenths
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    expq.push_back(exp);
    i_aux_led_host.access(a, 8'h00, 1'b0);
  endtask : rd
  // cycles between two drive values, sampled off the edge
  task automatic gap(input logic [5:0] a, input logic [5:0] b);
    for (n = 0; n < 3000 && d0 !== a; n++) @(negedge clk_sys);
    for (n = 0; n < 3000 && d0 !== b; n++) @(negedge clk_sys);
  endtask : gap
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // ==========
  // read result monitor
  always @(posedge clk_sys) re_q <= reg_re;
  always @(negedge clk_sys) if (re_q) check(reg_rdata, expq.pop_front());
  initial begin
    #2000000;
    n_fail++;
    results();
  end
  initial begin
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    for (int a = 8'h12; a < 8'h18; a++) rd(8'(a), 8'h00);
    for (int i = 0; i < 3; i++) begin
      v = rnd() | 8'hC0;
      cs[i] = v[5:0];
      i_aux_led_host.access(OFS_SINK0_CUR + 8'(i), v, 1'b1);
      rd(OFS_SINK0_CUR + 8'(i), {2'h0, v[5:0]});
    end
    v = rnd();
    i_aux_led_host.access(OFS_FADE_TIMES, v, 1'b1);
    rd(OFS_FADE_TIMES, v);
    i_aux_led_host.access(8'h17, 8'hFF, 1'b1);
    rd(8'h17, 8'h00);
    $display("register test done");
    i_aux_led_host.access(OFS_FADE_TIMES, 8'h00, 1'b1);
    en = 3'h7;
    @(negedge clk_sys);
    check({2'h0, d0}, {2'h0, cs[0]});
    check({2'h0, d1}, {2'h0, cs[1]});
    check({2'h0, d2}, {2'h0, cs[2]});
    check({5'h0, on}, {5'h0, cs[2] != 0, cs[1] != 0, cs[0] != 0});
    en = 3'h0;
    @(negedge clk_sys);
    check({2'h0, d0}, 8'h00);
    check({2'h0, d1 | d2}, 8'h00);
    $display("instant test done");
    i_aux_led_host.access(OFS_SINK0_CUR, 8'h02, 1'b1);
    foreach (cs[i]) begin
      v = (i == 0) ? 8'hB1 : (i == 1) ? 8'hFA : 8'h1F;
      i_aux_led_host.access(OFS_FADE_TIMES, v, 1'b1);
      en = 3'h1;
      gap(6'h01, 6'h02);
      check(8'(n), 8'(tenths(v[3:0]) * TICKS));
      en = 3'h0;
      gap(6'h01, 6'h00);
      check(8'(n), 8'(tenths(v[7:4]) * TICKS));
    end
    $display("fade test done");
    results();
  end
endmodule : aux_aux_fade_times_current_regs_tb_top

// *** tb/aux_led_chk.sv ***
`timescale 1ns/1ps
module aux_led_chk
  import aux_led_pkg::*;
#(parameter int TICK_CYCLES = FADE_TICK_CYC)(
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_we,
  input wire logic              reg_re,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic [SINKS-1:0]  aux_sink_enable,
  input wire logic [CODE_W-1:0] sink0_drive,
  input wire logic [CODE_W-1:0] sink1_drive,
  input wire logic [CODE_W-1:0] sink2_drive,
  input wire logic [SINKS-1:0]  sink_on
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========
  // register shadows
  logic [DATA_W-1:0] fade_r;
  logic [CODE_W-1:0] c0_r;
  logic [CODE_W-1:0] c1_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fade_r <= '0;
      c0_r   <= '0;
      c1_r   <= '0;
    end else if (reg_we) begin
      if (reg_addr == OFS_FADE_TIMES) fade_r <= reg_wdata;
      if (reg_addr == OFS_SINK0_CUR) c0_r <= reg_wdata[5:0];
      if (reg_addr == OFS_SINK1_CUR) c1_r <= reg_wdata[5:0];
    end
  end
  // ==========
  // fade tick reference, one pulse every TICK_CYCLES cycles
  localparam int TW = $clog2(TICK_CYCLES + 1);
  logic [TW-1:0] tcnt_r;
  logic          tick_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tcnt_r <= '0;
      tick_q <= 1'b0;
    end else begin
      tcnt_r <= (tcnt_r == TW'(TICK_CYCLES - 1)) ? '0 : tcnt_r + TW'(1);
      tick_q <= tcnt_r == TW'(TICK_CYCLES - 1);
    end
  end
  AST_RD_HOLD: assert property (
    !reg_re |=> $stable(reg_rdata)) else $error("read data moved");
  AST_RD_GAP: assert property (
    reg_re && (reg_addr < OFS_FADE_TIMES || reg_addr > OFS_SINK2_CUR) |=> reg_rdata == RD_UNMAPPED)
    else $error("unmapped read not zero");
  AST_RD_FADE: assert property (
    reg_re && reg_addr == OFS_FADE_TIMES |=> reg_rdata == $past(fade_r)) else $error("fade read wrong");
  AST_RD_SINK: assert property (
    reg_re && reg_addr == OFS_SINK1_CUR |=> reg_rdata == {2'h0, $past(c1_r)}) else $error("sink1 read wrong");
  AST_ON: assert property (
    sink_on == {sink2_drive != 0, sink1_drive != 0, sink0_drive != 0}) else $error("sink_on wrong");
  AST_OFF_NOW: assert property (
    !aux_sink_enable[0] && fade_r[7:4] == 4'h0 |=> sink0_drive == 6'h00) else $error("no instant off");
  AST_ON_NOW: assert property (
    aux_sink_enable[0] && fade_r == 8'h00 |=> sink0_drive == $past(c0_r)) else $error("no instant on");
  AST_STEP: assert property (
    fade_r[7:4] != 4'h0 && fade_r[3:0] != 4'h0 |=> sink0_drive == $past(sink0_drive)
    || sink0_drive == $past(sink0_drive) + 6'h01 || sink0_drive == $past(sink0_drive) - 6'h01)
    else $error("ramp jumped");
  AST_PACE: assert property (
    !tick_q && fade_r[7:4] != 4'h0 && fade_r[3:0] != 4'h0 |=> $stable(sink0_drive)) else $error("step off tick");
endmodule : aux_led_chk
bind aux_aux_fade_times_current_regs aux_led_chk #(.TICK_CYCLES(TICK_CYCLES)) i_aux_led_chk (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
  .reg_re(reg_re), .reg_rdata(reg_rdata), .aux_sink_enable(aux_sink_enable), .sink0_drive(sink0_drive),
  .sink1_drive(sink1_drive), .sink2_drive(sink2_drive), .sink_on(sink_on));

// *** tb/aux_led_host.sv ***
`timescale 1ns/1ps
module aux_led_host
  import aux_led_pkg::*;
(
  input  wire logic              clk_sys,
  output logic      [ADDR_W-1:0] reg_addr,
  output logic      [DATA_W-1:0] reg_wdata,
  output logic                   reg_we,
  output logic                   reg_re
);
  initial begin
    reg_addr  = '0;
    reg_wdata = '0;
    reg_we    = 1'b0;
    reg_re    = 1'b0;
  end
  // one byte per access, idle bus shows inverted values
  task automatic access(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic w);
    @(negedge clk_sys);
    reg_addr  = a;
    reg_wdata = d;
    reg_we    = w;
    reg_re    = !w;
    @(negedge clk_sys);
    reg_we    = 1'b0;
    reg_re    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : access
endmodule : aux_led_host
